// ---- rtl/scp_defines.svh ----
// Constants of the serial configuration port
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

`define SCP_WORD_BITS      16
`define SCP_ADDR_BITS      5
`define SCP_DATA_BITS      11
`define SCP_NUM_REGS       32
`define SCP_ADDR_CTRL      5'h00
`define SCP_ADDR_MODE      5'h0d
`define SCP_CTRL_RST_BIT   10
`define SCP_CTRL_REF_BIT   5
`define SCP_CTRL_PDB_BIT   3
`define SCP_CTRL_PDA_BIT   2
`define SCP_CTRL_PDG_BIT   0
`define SCP_MODE_OVRD_BIT  10
`define SCP_MODE_MSB_BIT   6
`define SCP_MODE_GAIN_BIT  5
`define SCP_MODE_EDGE_BIT  4
`define SCP_MODE_W14_BIT   2
`define SCP_MODE_SDR_BIT   1
`define SCP_MODE_2W_BIT    0
`define SCP_DATA_FMT_ADDR  5'h0a
`define SCP_DATA_FMT_BIT   9
`define SCP_REG_RESET      11'h000
`define SCP_SYS_CLK_PS     8000
`define SCP_SETTLE_PS      100000
`define SCP_SETTLE_CYC \
  ((`SCP_SETTLE_PS + `SCP_SYS_CLK_PS - 1) / `SCP_SYS_CLK_PS)
`define SCP_STRAP_GND      2'h0
`define SCP_STRAP_THREE    2'h1
`define SCP_STRAP_FIVE     2'h2
`define SCP_STRAP_FULL     2'h3

`endif

// ---- rtl/scp_pkg.sv ----
// Types shared by the serial configuration port
`default_nettype none
package scp_pkg;
  typedef logic [1:0]  scp_strap_type;
  typedef logic [4:0]  scp_addr_type;
  typedef logic [10:0] scp_data_type;
  typedef enum logic [1:0] {
    SCP_LINK_DDR_1W,
    SCP_LINK_UNUSED,
    SCP_LINK_SDR_2W,
    SCP_LINK_DDR_2W
  } scp_link_type;
endpackage
`default_nettype wire

// ---- rtl/scp_shifter.sv ----
// Shift-clock side: assembles 16-bit words under select
`default_nettype none
`include "scp_defines.svh"
module scp_shifter
  import scp_pkg::*;
(
  // Link
  input  wire logic                 shift_clk,
  input  wire logic                 config_select_n,
  input  wire logic                 config_serial_in,
  // Word out, held until next word
  output logic     [15:0]           word_q,
  output logic                      word_tog_q = 1'b0
);
  logic [3:0]  count_q;
  logic [14:0] sr_q;

  // Select high clears the count asynchronously, so a frame always starts
  // at bit zero even though the shift clock may stop between frames.
  always_ff @(negedge shift_clk or posedge config_select_n) begin
    if (config_select_n) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_q + 4'h1;
    end
  end

  always_ff @(negedge shift_clk) begin
    if (!config_select_n) begin
      sr_q <= {sr_q[13:0], config_serial_in};
    end
  end

  // Only full words leave; a partial tail never raises the toggle
  always_ff @(negedge shift_clk) begin
    if (!config_select_n && count_q == 4'hf) begin
      word_q     <= {sr_q, config_serial_in};
      word_tog_q <= ~word_tog_q;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/scp_strap_decode.sv ----
// Strap code decoder for link, serialize and bit-order modes
`default_nettype none
`include "scp_defines.svh"
module scp_strap_decode
  import scp_pkg::*;
(
  // Strap codes
  input  wire scp_strap_type        link_code,
  input  wire scp_strap_type        ser_code,
  input  wire scp_strap_type        order_code,
  // Decoded modes
  output logic                      two_wire,
  output logic                      sdr_clock,
  output logic                      width_14,
  output logic                      rising_edge,
  output logic                      lsb_first,
  output logic                      offset_binary
);
  always_comb begin
    two_wire  = 1'b0;
    sdr_clock = 1'b0;
    case (scp_link_type'(link_code))
      SCP_LINK_SDR_2W: begin
        two_wire  = 1'b1;
        sdr_clock = 1'b1;
      end
      SCP_LINK_DDR_2W: two_wire = 1'b1;
      default: two_wire = 1'b0;
    endcase
    width_14    = (ser_code == `SCP_STRAP_THREE) ||
                  (ser_code == `SCP_STRAP_FIVE);
    rising_edge = ser_code[1];
    lsb_first     = order_code[1];
    offset_binary = (order_code == `SCP_STRAP_THREE) ||
                    (order_code == `SCP_STRAP_FIVE);
  end
endmodule
`default_nettype wire

// ---- rtl/scp_top.sv ----
// Serial configuration port: register file, reset and strap muxing
`default_nettype none
`include "scp_defines.svh"
module scp_top
  import scp_pkg::*;
#(
  parameter int SETTLE_CYC = `SCP_SETTLE_CYC
) (
  // System
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Serial link
  input  wire logic                 shift_clk,
  input  wire logic                 config_select_n,
  input  wire logic                 config_serial_in,
  input  wire logic                 hw_reset_pin,
  // Straps
  input  wire scp_strap_type        select_strap,
  input  wire logic                 chan_a_sleep_pin,
  input  wire logic                 chan_b_sleep_pin,
  input  wire scp_strap_type        link_width_clock_strap,
  input  wire scp_strap_type        serialize_edge_strap,
  input  wire scp_strap_type        reserved_strap,
  input  wire scp_strap_type        bit_order_format_strap,
  // Applied modes
  output logic                      internal_ref_q,
  output logic                      coarse_gain_q,
  output logic                      chan_a_down_q,
  output logic                      chan_b_down_q,
  output logic                      global_down_q,
  output logic                      two_wire_q,
  output logic                      sdr_clock_q,
  output logic                      width_14_q,
  output logic                      rising_edge_q,
  output logic                      lsb_first_q,
  output logic                      offset_binary_q,
  output logic                      write_done_q
);
  import scp_pkg::*;

  logic [15:0]   word;
  logic          word_tog;
  logic [2:0]    tog_sync_q;
  logic [2:0]    hwr_sync_q;
  logic [1:0]    sa_q, sb_q;
  scp_strap_type sel_s1_q, sel_q, lk_s1_q, lk_q;
  scp_strap_type se_s1_q, se_q, bo_s1_q, bo_q;
  scp_data_type  regs_q [`SCP_NUM_REGS];
  logic          pend_q;
  logic [15:0]   pend_word_q;
  logic [7:0]    settle_q;
  logic          st_two, st_sdr, st_w14, st_rise, st_lsb, st_ofs;
  logic          hw_reset;
  logic          commit;
  scp_addr_type  c_addr;
  scp_data_type  c_data;
  scp_data_type  ctrl, mode;
  logic          ovrd;

  // Reserved strap is ignored by design
  wire unused_ok = ^reserved_strap;

  scp_shifter u_shift (
    .shift_clk        (shift_clk),
    .config_select_n  (config_select_n),
    .config_serial_in (config_serial_in),
    .word_q           (word),
    .word_tog_q       (word_tog)
  );

  // Toggle crossing; word is stable long before the toggle is seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_sync_q <= 3'h0;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], word_tog};
    end
  end

  // Reset pin: two stages then one more to see a pulse; 10 ns is over one
  // sys_clk period so a legal pulse is always caught
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hwr_sync_q <= 3'h0;
    end else begin
      hwr_sync_q <= {hwr_sync_q[1:0], hw_reset_pin};
    end
  end
  assign hw_reset = hwr_sync_q[1] | hwr_sync_q[2];

  // Static straps still pass two stages
  always_ff @(posedge sys_clk) begin
    sa_q     <= {sa_q[0], chan_a_sleep_pin};
    sb_q     <= {sb_q[0], chan_b_sleep_pin};
    sel_s1_q <= select_strap;
    sel_q    <= sel_s1_q;
    lk_s1_q  <= link_width_clock_strap;
    lk_q     <= lk_s1_q;
    se_s1_q  <= serialize_edge_strap;
    se_q     <= se_s1_q;
    bo_s1_q  <= bit_order_format_strap;
    bo_q     <= bo_s1_q;
  end

  // New word captured, then held back for the settle time
  always_ff @(posedge sys_clk) begin
    if (rst || hw_reset) begin
      pend_q      <= 1'b0;
      pend_word_q <= 16'h0000;
      settle_q    <= 8'h00;
    end else if (tog_sync_q[2] != tog_sync_q[1]) begin
      pend_q      <= 1'b1;
      pend_word_q <= word;
      settle_q    <= 8'(SETTLE_CYC);
    end else if (pend_q) begin
      if (settle_q <= 8'h1) begin
        pend_q <= 1'b0;
      end
      settle_q <= settle_q - 8'h1;
    end
  end

  assign commit = pend_q && (settle_q <= 8'h1);
  assign c_addr = pend_word_q[15:11];
  assign c_data = pend_word_q[10:0];

  // Register file; software reset bit resets all and never stores
  always_ff @(posedge sys_clk) begin
    if (rst || hw_reset) begin
      for (int i = 0; i < `SCP_NUM_REGS; i++) begin
        regs_q[i] <= `SCP_REG_RESET;
      end
    end else if (commit) begin
      if (c_addr == `SCP_ADDR_CTRL && c_data[`SCP_CTRL_RST_BIT]) begin
        for (int i = 0; i < `SCP_NUM_REGS; i++) begin
          regs_q[i] <= `SCP_REG_RESET;
        end
      end else begin
        regs_q[c_addr] <= c_data;
      end
    end
  end

  assign ctrl = regs_q[`SCP_ADDR_CTRL];
  assign mode = regs_q[`SCP_ADDR_MODE];
  assign ovrd = mode[`SCP_MODE_OVRD_BIT];

  scp_strap_decode u_dec (
    .link_code     (lk_q),
    .ser_code      (se_q),
    .order_code    (bo_q),
    .two_wire      (st_two),
    .sdr_clock     (st_sdr),
    .width_14      (st_w14),
    .rising_edge   (st_rise),
    .lsb_first     (st_lsb),
    .offset_binary (st_ofs)
  );

  // Outputs settle a few cycles after reset, far inside 6.5 ms
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      internal_ref_q  <= 1'b0;
      coarse_gain_q   <= 1'b0;
      chan_a_down_q   <= 1'b0;
      chan_b_down_q   <= 1'b0;
      global_down_q   <= 1'b0;
      two_wire_q      <= 1'b0;
      sdr_clock_q     <= 1'b0;
      width_14_q      <= 1'b0;
      rising_edge_q   <= 1'b0;
      lsb_first_q     <= 1'b0;
      offset_binary_q <= 1'b0;
    end else begin
      // Strap picks reference; register bit may also enable it
      internal_ref_q <= sel_q[1] | ctrl[`SCP_CTRL_REF_BIT];
      coarse_gain_q  <= ovrd ? mode[`SCP_MODE_GAIN_BIT]
                             : (sel_q == `SCP_STRAP_THREE ||
                                sel_q == `SCP_STRAP_FIVE);
      chan_a_down_q  <= sa_q[1] | ctrl[`SCP_CTRL_PDA_BIT];
      chan_b_down_q  <= sb_q[1] | ctrl[`SCP_CTRL_PDB_BIT];
      global_down_q  <= ctrl[`SCP_CTRL_PDG_BIT];
      if (ovrd) begin
        two_wire_q    <= mode[`SCP_MODE_2W_BIT];
        sdr_clock_q   <= mode[`SCP_MODE_SDR_BIT];
        width_14_q    <= mode[`SCP_MODE_W14_BIT];
        rising_edge_q <= mode[`SCP_MODE_EDGE_BIT];
        lsb_first_q   <= mode[`SCP_MODE_MSB_BIT];
        offset_binary_q <=
          regs_q[`SCP_DATA_FMT_ADDR][`SCP_DATA_FMT_BIT];
      end else begin
        two_wire_q      <= st_two;
        sdr_clock_q     <= st_sdr;
        width_14_q      <= st_w14;
        rising_edge_q   <= st_rise;
        lsb_first_q     <= st_lsb;
        offset_binary_q <= st_ofs;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_done_q <= 1'b0;
    end else begin
      write_done_q <= commit;
    end
  end

  // Assertions
  // Cycles since the last toggle edge, saturating; repeating over the
  // whole settle span would be too long for the tools to unroll
  logic [7:0] age_q;
  always_ff @(posedge sys_clk) begin
    if (rst || hw_reset) begin
      age_q <= 8'hff;
    end else if (tog_sync_q[2] != tog_sync_q[1]) begin
      age_q <= 8'h00;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end

  property p_settle;
    @(posedge sys_clk) disable iff (rst || hw_reset)
      commit |-> age_q >= 8'h0c;
  endproperty
  a_settle: assert property (p_settle)
    else $error("commit too early");
  property p_commit_bound;
    @(posedge sys_clk) disable iff (rst || hw_reset)
      (tog_sync_q[2] != tog_sync_q[1]) |-> ##[12:14] write_done_q;
  endproperty
  a_commit_bound: assert property (p_commit_bound)
    else $error("write not committed");
  property p_swrst;
    @(posedge sys_clk) disable iff (rst || hw_reset)
      (commit && c_addr == `SCP_ADDR_CTRL && c_data[`SCP_CTRL_RST_BIT])
      |=> (ctrl == `SCP_REG_RESET) && (mode == `SCP_REG_RESET);
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("soft reset failed");
  property p_hwrst;
    @(posedge sys_clk) disable iff (rst) hw_reset |=> mode == 11'h000;
  endproperty
  a_hwrst: assert property (p_hwrst)
    else $error("hw reset failed");
  property p_write;
    @(posedge sys_clk) disable iff (rst || hw_reset)
      (commit && c_addr == `SCP_ADDR_MODE) |=> mode == $past(c_data);
  endproperty
  a_write: assert property (p_write)
    else $error("write lost");
  // Outputs follow the register one cycle late, so compare to last value
  property p_ovrd;
    @(posedge sys_clk) disable iff (rst)
      (ovrd && $stable(mode)) |=>
        two_wire_q == $past(mode[`SCP_MODE_2W_BIT]);
  endproperty
  a_ovrd: assert property (p_ovrd)
    else $error("override ignored");
  property p_strap;
    @(posedge sys_clk) disable iff (rst)
      !ovrd |=> (lsb_first_q == $past(st_lsb)) &&
                (width_14_q == $past(st_w14));
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap ignored");
  property p_sleep;
    @(posedge sys_clk) disable iff (rst) sa_q[1] |=> chan_a_down_q;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("chan a awake");
  property p_sleep_b;
    @(posedge sys_clk) disable iff (rst) sb_q[1] |=> chan_b_down_q;
  endproperty
  a_sleep_b: assert property (p_sleep_b)
    else $error("chan b awake");
  property p_gain;
    @(posedge sys_clk) disable iff (rst)
      (!ovrd && sel_q == `SCP_STRAP_GND) |=> !coarse_gain_q;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain wrong");
  property p_gain_up;
    @(posedge sys_clk) disable iff (rst)
      (!ovrd && (sel_q == `SCP_STRAP_THREE || sel_q == `SCP_STRAP_FIVE))
      |=> coarse_gain_q;
  endproperty
  a_gain_up: assert property (p_gain_up)
    else $error("gain not raised");
  property p_ref;
    @(posedge sys_clk) disable iff (rst) sel_q[1] |=> internal_ref_q;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference not internal");
  property p_link_unused;
    @(posedge sys_clk) disable iff (rst)
      (!ovrd && lk_q == `SCP_STRAP_THREE) |=> !two_wire_q && !sdr_clock_q;
  endproperty
  a_link_unused: assert property (p_link_unused)
    else $error("unused link code decoded");
  property p_fmt;
    @(posedge sys_clk) disable iff (rst)
      (!ovrd && bo_q == `SCP_STRAP_FULL) |=> lsb_first_q && !offset_binary_q;
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("bit order wrong");

  c_write: cover property (@(posedge sys_clk) commit);
  c_swrst: cover property (@(posedge sys_clk)
    commit && c_addr == `SCP_ADDR_CTRL && c_data[`SCP_CTRL_RST_BIT]);
  c_ovrd: cover property (@(posedge sys_clk) ovrd);
  c_hwrst: cover property (@(posedge sys_clk) hw_reset);
  c_sdr: cover property (@(posedge sys_clk) two_wire_q && sdr_clock_q);
endmodule
`default_nettype wire

// ---- sim/scp_host_model.sv ----
// Host controller model driving the three-wire configuration link
`default_nettype none
module scp_host_model (
  // Link lines
  output var logic shift_clk,
  output var logic config_select_n,
  output var logic config_serial_in
);
  timeunit 1ns;
  timeprecision 100ps;
  realtime last_word_t = 0;
  initial begin
    shift_clk = 1'b1;
    config_select_n = 1'b1;
    config_serial_in = 1'b0;
  end
  // Sends n bits, oldest first, under one select period
  task automatic send(input logic [47:0] bits, input int n,
                      input realtime hi, input realtime lo);
    config_select_n = 1'b0;
    #25;
    for (int i = n - 1; i >= 0; i--) begin
      config_serial_in = bits[i];
      #(hi);
      shift_clk = 1'b0;
      if ((n - i) % 16 == 0) last_word_t = $realtime;
      #(lo);
      shift_clk = 1'b1;
    end
    #25;
    config_select_n = 1'b1;
    // Released line flips so a stale sample cannot match by luck
    config_serial_in = ~config_serial_in;
    // Deselect gap, so a following frame never lowers select in this step
    #25;
  endtask
  // Clock pulses while deselected; the port must ignore them
  task automatic stray(input int n);
    repeat (n) begin
      config_serial_in = ~config_serial_in;
      #7.5 shift_clk = 1'b0;
      #7.5 shift_clk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/scp_top_tb.sv ----
// Self-checking bench of the serial configuration port
`default_nettype none
module scp_top_tb
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic          hw_reset_pin = 1'b0;
  logic          shift_clk;
  logic          config_select_n;
  logic          config_serial_in;
  logic          pa = 1'b0;
  logic          pb = 1'b0;
  scp_strap_type sel_s = 2'h0;
  scp_strap_type link_s = 2'h0;
  scp_strap_type ser_s = 2'h0;
  scp_strap_type ord_s = 2'h0;
  wire [10:0]    modes;
  logic          write_done_q;
  logic [10:0]   r00 = 11'h000;
  logic [10:0]   r0d = 11'h000;
  logic [21:0]   exp_q[$];
  logic [15:0]   w1;
  logic [15:0]   w2;
  logic [31:0]   r;
  int            failures = 0;
  int            n_tests = 0;
  int            cyc = 0;
  bit            sw_ok = 1'b0;

  always #4 sys_clk = ~sys_clk;

  scp_host_model host (
    .shift_clk(shift_clk),
    .config_select_n(config_select_n),
    .config_serial_in(config_serial_in)
  );

  scp_top DUT (
    .sys_clk(sys_clk), .rst(rst), .shift_clk(shift_clk),
    .config_select_n(config_select_n),
    .config_serial_in(config_serial_in), .hw_reset_pin(hw_reset_pin),
    .select_strap(sel_s), .chan_a_sleep_pin(pa), .chan_b_sleep_pin(pb),
    .link_width_clock_strap(link_s), .serialize_edge_strap(ser_s),
    .reserved_strap(2'h0),
    .bit_order_format_strap(ord_s),
    .internal_ref_q(modes[10]), .coarse_gain_q(modes[9]),
    .chan_a_down_q(modes[8]), .chan_b_down_q(modes[7]),
    .global_down_q(modes[6]), .two_wire_q(modes[5]),
    .sdr_clock_q(modes[4]), .width_14_q(modes[3]),
    .rising_edge_q(modes[2]), .lsb_first_q(modes[1]),
    .offset_binary_q(modes[0]), .write_done_q(write_done_q)
  );

  // Expected {mask, value}; width and edge only checked in 2-wire SDR, offset format only without override
  function automatic logic [21:0] model();
    logic        ov;
    logic [10:0] v;
    ov = r0d[10];
    v[10] = sel_s[1] | r00[5];
    v[9] = ov ? r0d[5] : ^sel_s;
    v[8] = pa | r00[2];
    v[7] = pb | r00[3];
    v[6] = r00[0];
    v[5] = ov ? r0d[0] : link_s[1];
    v[4] = ov ? r0d[1] : (link_s == 2'h2);
    v[3] = ov ? r0d[2] : ^ser_s;
    v[2] = ov ? r0d[4] : ser_s[1];
    v[1] = ov ? r0d[6] : ord_s[1];
    v[0] = ^ord_s;
    return {7'h7f, {2{v[5] & v[4]}}, 1'b1, ~ov, v};
  endfunction

  function automatic logic [15:0] note(input logic [4:0] a,
                                       input logic [10:0] d);
    if (a == 5'h00) r00 = d;
    if (a == 5'h0d) r0d = d;
    exp_q.push_back(model());
    return {a, d};
  endfunction

  function automatic logic [10:0] rnd(input logic [4:0] a);
    r = $urandom;
    if (a == 5'h00) return {5'h00, r[5], 1'b0, r[3:2], 1'b0, r[0]};
    return {1'b1, 3'h0, r[6:4], 1'b0, r[2:0]};
  endfunction

  task automatic fail(input string msg);
    failures++;
    $display("wrong value at %0t: %s", $realtime, msg);
  endtask

  task automatic cmp_modes(input logic [21:0] e);
    // Look after the edge, once the registered outputs have settled
    #1;
    n_tests++;
    if (((modes ^ e[10:0]) & e[21:11]) !== 11'h000) fail("mode outputs");
  endtask

  task automatic cmp_time(input realtime d);
    n_tests++;
    if (d < 100.0 || d > 180.0) fail("write latency");
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic power_up(input logic [1:0] c);
    @(posedge sys_clk);
    {sel_s, link_s, ser_s, ord_s} <= {4{c}};
    pa <= 1'($urandom);
    pb <= 1'($urandom);
    rst <= 1'b1;
    cycles(4);
    rst <= 1'b0;
    r00 = 11'h000;
    r0d = 11'h000;
    cycles(10);
    cmp_modes(model());
  endtask

  task automatic hw_pulse();
    @(posedge sys_clk);
    hw_reset_pin <= 1'b1;
    cycles(2);
    hw_reset_pin <= 1'b0;
    r00 = 11'h000;
    r0d = 11'h000;
    cycles(8);
    cmp_modes(model());
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Results arrive on write_done_q; outputs settle one cycle later
  always @(posedge sys_clk) begin
    if (write_done_q === 1'b1) begin
      cmp_time($realtime - host.last_word_t);
      @(posedge sys_clk);
      #1;
      if (exp_q.size() > 0) cmp_modes(exp_q.pop_front());
      else if (!sw_ok) fail("unexpected commit");
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail("timeout");
      close_out();
    end
  end

  initial begin
    void'($urandom(47));
    for (int c = 0; c < 4; c++) power_up(2'(c));
    // Power-on wait is shortened: the port has no supply timer of its own
    hw_pulse();
    w1 = note(5'h0d, rnd(5'h0d));
    host.send({32'h0, w1}, 16, 7.5, 7.5);
    cycles(30);
    // Two words and a ragged tail in one select period
    w1 = note(5'h00, rnd(5'h00));
    w2 = note(5'h0d, rnd(5'h0d));
    host.send({9'h0, w1, w2, 7'($urandom)}, 39, 7.5, 7.5);
    cycles(40);
    host.stray(5);
    host.send(48'($urandom), 9, 7.5, 7.5);
    w1 = note(5'h0d, 11'h000);
    host.send({32'h0, w1}, 16, 7.5, 7.5);
    cycles(40);
    // Slow, lopsided shift clock
    w1 = note(5'h0d, rnd(5'h0d));
    host.send({32'h0, w1}, 16, 40, 400);
    cycles(40);
    sw_ok = 1'b1;
    host.send({32'h0, 5'h00, 11'h400}, 16, 7.5, 7.5);
    r00 = 11'h000;
    r0d = 11'h000;
    cycles(40);
    cmp_modes(model());
    sw_ok = 1'b0;
    for (int i = 0; i < 6; i++) begin
      w1 = note(i[0] ? 5'h0d : 5'h00, rnd(i[0] ? 5'h0d : 5'h00));
      host.send({32'h0, w1}, 16, 7.5, 7.5);
      cycles(30);
    end
    hw_pulse();
    cycles(40);
    n_tests++;
    if (exp_q.size() != 0) fail("missing commit");
    close_out();
  end
endmodule
`default_nettype wire
